// ---- pcom_map.svh ----
// register map, field positions, reset values and timing figures of the period counter
`ifndef PCOM_MAP_SVH
`define PCOM_MAP_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define PCOM_ADDR_W         8
`define PCOM_OFS_CTRL       8'h00
`define PCOM_OFS_PERIOD     8'h04
`define PCOM_OFS_COUNT      8'h08

// ---------------------------------------------------------------
// control register fields
// ---------------------------------------------------------------
`define PCOM_BIT_ROLE       0
`define PCOM_BIT_INVERT     1
`define PCOM_BIT_GPVAL      2
`define PCOM_BIT_WIDTH      4
`define PCOM_BIT_RESTART    6
`define PCOM_BIT_ALLOW      7
`define PCOM_BIT_CLKMODE    8
`define PCOM_BIT_STATE      11

// ---------------------------------------------------------------
// reset values and timing
// ---------------------------------------------------------------
`define PCOM_RST_WORD       32'h0000_0000
`define PCOM_RST_BIT        1'h0
`define PCOM_CPU_MHZ        50
`define PCOM_TICK_DIV       4
`define PCOM_WIDTH_ONE      2'h1
`define PCOM_WIDTH_TWO      2'h2

`endif

// ---- pcom_pkg.sv ----
// types shared by the period counter files
package pcom_pkg;

	// software control fields
	typedef struct packed {
		logic clock_pulse_select;
		logic count_allow;
		logic pulse_width_select;
		logic gp_output_value;
		logic output_invert;
		logic output_pin_role;
	} pcom_ctrl_type;

	// plain register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} pcom_req_type;

endpackage

// ---- pcom_tick_gen.sv ----
// timer input clock: one-cycle tick every div cpu clocks
`include "pcom_map.svh"

module pcom_tick_gen
	import pcom_pkg::*;
#(
	parameter int DIV = `PCOM_TICK_DIV
)(
	// clock and reset
	input  wire logic i_core_clk,
	input  wire logic i_nrst,
	// control
	input  wire logic i_restart,
	// tick
	output logic      o_tick
);

	localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] div_q;

	// free-running divider, realigned by a restart
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			div_q <= '0;
		else if (i_restart || div_q == LAST)
			div_q <= '0;
		else
			div_q <= div_q + CW'(1);
	end

	assign o_tick = (div_q == LAST) && !i_restart;

endmodule

// ---- pcom_timer.sv ----
// period counter with status generation, output pin mux and register port
`include "pcom_map.svh"

module pcom_timer
	import pcom_pkg::*;
#(
	parameter int TICK_DIV = `PCOM_TICK_DIV
)(
	// clock and reset
	input  wire logic        i_core_clk,
	input  wire logic        i_nrst,
	// register port
	input  wire logic [7:0]  i_addr,
	input  wire logic [31:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [31:0] o_rdata,
	// pin and status
	output logic             o_timer_out_pin,
	output logic             o_timer_state_output
);

	// ---------------------------------------------------------------
	// register port decode
	// ---------------------------------------------------------------
	pcom_req_type  req;
	pcom_ctrl_type ctrl_q;
	logic [31:0]   period_value_q;
	logic [31:0]   count_value_q;
	logic          state_q;
	logic [1:0]    wid_cnt_q;
	logic          pin_q;
	logic          wr_ctrl;
	logic          wr_period;
	logic          wr_count;
	logic          restart;
	logic          tick;
	logic          hit;
	logic [1:0]    wid_target;

	assign req = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// address compare used by every strobe
	function automatic logic sel(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction

	assign wr_ctrl   = req.wr && sel(req.addr, `PCOM_OFS_CTRL);
	assign wr_period = req.wr && sel(req.addr, `PCOM_OFS_PERIOD);
	assign wr_count  = req.wr && sel(req.addr, `PCOM_OFS_COUNT);
	assign restart   = wr_ctrl && req.wdata[`PCOM_BIT_RESTART] && req.wdata[`PCOM_BIT_ALLOW];

	// control fields, restart bit is write-only
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			ctrl_q <= '0;
		else if (wr_ctrl)
		begin
			ctrl_q.output_pin_role    <= req.wdata[`PCOM_BIT_ROLE];
			ctrl_q.output_invert      <= req.wdata[`PCOM_BIT_INVERT];
			ctrl_q.gp_output_value    <= req.wdata[`PCOM_BIT_GPVAL];
			ctrl_q.pulse_width_select <= req.wdata[`PCOM_BIT_WIDTH];
			ctrl_q.count_allow        <= req.wdata[`PCOM_BIT_ALLOW];
			ctrl_q.clock_pulse_select <= req.wdata[`PCOM_BIT_CLKMODE];
		end
	end

	// period register, full 32 bits
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			period_value_q <= `PCOM_RST_WORD;
		else if (wr_period)
			period_value_q <= req.wdata;
	end

	// read data, valid in the cycle after the read strobe only
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_rdata <= `PCOM_RST_WORD;
		else if (!req.rd)
			o_rdata <= `PCOM_RST_WORD;
		else if (sel(req.addr, `PCOM_OFS_CTRL))
		begin
			o_rdata                       <= `PCOM_RST_WORD;
			o_rdata[`PCOM_BIT_ROLE]       <= ctrl_q.output_pin_role;
			o_rdata[`PCOM_BIT_INVERT]     <= ctrl_q.output_invert;
			o_rdata[`PCOM_BIT_GPVAL]      <= ctrl_q.gp_output_value;
			o_rdata[`PCOM_BIT_WIDTH]      <= ctrl_q.pulse_width_select;
			o_rdata[`PCOM_BIT_ALLOW]      <= ctrl_q.count_allow;
			o_rdata[`PCOM_BIT_CLKMODE]    <= ctrl_q.clock_pulse_select;
			o_rdata[`PCOM_BIT_STATE]      <= state_q;
		end
		else if (sel(req.addr, `PCOM_OFS_PERIOD))
			o_rdata <= period_value_q;
		else if (sel(req.addr, `PCOM_OFS_COUNT))
			o_rdata <= count_value_q;
		else
			o_rdata <= `PCOM_RST_WORD; // unmapped reads zero
	end

	// ---------------------------------------------------------------
	// timer input clock and counter
	// ---------------------------------------------------------------
	pcom_tick_gen #(
		.DIV        (TICK_DIV)
	) u_tick (
		.i_core_clk (i_core_clk),
		.i_nrst     (i_nrst),
		.i_restart  (restart),
		.o_tick     (tick)
	);

	// period match while counting is allowed
	assign hit = ctrl_q.count_allow && (count_value_q == period_value_q);

	// count: write, restart, wrap to zero, then step
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			count_value_q <= `PCOM_RST_WORD;
		else if (wr_count)
			count_value_q <= req.wdata;
		else if (restart)
			count_value_q <= `PCOM_RST_WORD;
		else if (hit)
			count_value_q <= `PCOM_RST_WORD;
		else if (tick && ctrl_q.count_allow)
			count_value_q <= count_value_q + 32'h0000_0001;
	end

	// ---------------------------------------------------------------
	// status output
	// ---------------------------------------------------------------
	assign wid_target = ctrl_q.pulse_width_select ? `PCOM_WIDTH_TWO : `PCOM_WIDTH_ONE;

	// clock mode toggles on each match, pulse mode sets then times out
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			state_q <= `PCOM_RST_BIT;
		else if (ctrl_q.clock_pulse_select)
		begin
			if (hit)
				state_q <= !state_q;
		end
		else if (hit)
			state_q <= 1'h1;
		else if (state_q && tick && (wid_cnt_q + 2'h1) >= wid_target)
			state_q <= 1'h0;
	end

	// ticks seen while the status is high since the last match, held at two
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			wid_cnt_q <= '0;
		else if (hit)
			wid_cnt_q <= '0;
		else if (state_q && tick && wid_cnt_q != `PCOM_WIDTH_TWO)
			wid_cnt_q <= wid_cnt_q + 2'h1;
	end

	// ---------------------------------------------------------------
	// pin mux
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			pin_q <= `PCOM_RST_BIT;
		else if (ctrl_q.output_pin_role)
			pin_q <= ctrl_q.output_invert ? !state_q : state_q;
		else
			pin_q <= ctrl_q.gp_output_value;
	end

	assign o_timer_out_pin      = pin_q;
	assign o_timer_state_output = state_q;

	// ---------------------------------------------------------------
	// assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);

	a_count_wrap_zero: assert property (hit && !wr_count && !restart |=> count_value_q == 32'h0)
		else $error("count did not wrap after period match");
	a_count_step_one: assert property (tick && ctrl_q.count_allow && !hit && !wr_count && !restart
		|=> count_value_q == $past(count_value_q) + 32'h1)
		else $error("count did not step by one");
	a_count_hold_off: assert property (!ctrl_q.count_allow && !wr_count && !wr_ctrl |=> $stable(count_value_q))
		else $error("count moved while not allowed");
	a_restart_clears: assert property (restart && !wr_count
		|=> count_value_q == 32'h0 && (restart || tick == (TICK_DIV == 1)))
		else $error("restart did not clear count");
	a_period_write: assert property (wr_period |=> period_value_q == $past(req.wdata))
		else $error("period write lost");
	a_pulse_rise: assert property (hit && !ctrl_q.clock_pulse_select |=> state_q)
		else $error("pulse not raised after match");
	a_clock_toggle: assert property (hit && ctrl_q.clock_pulse_select |=> state_q != $past(state_q))
		else $error("clock mode did not toggle");
	a_pulse_one_tick: assert property (hit && !ctrl_q.clock_pulse_select && !ctrl_q.pulse_width_select
		&& !wr_ctrl ##1 tick && !hit && !wr_ctrl |=> !state_q)
		else $error("one-tick pulse too long");
	a_pin_timer_role: assert property (ctrl_q.output_pin_role |=> pin_q == ($past(state_q) ^ $past(ctrl_q.output_invert)))
		else $error("pin not driven by status");
	a_pin_gp_role: assert property (!ctrl_q.output_pin_role |=> pin_q == $past(ctrl_q.gp_output_value))
		else $error("pin not driven by general output value");
	a_count_read: assert property (req.rd && sel(req.addr, `PCOM_OFS_COUNT) |=> o_rdata == $past(count_value_q))
		else $error("count read mismatch");

	c_period_match: cover property (hit ##1 count_value_q == 32'h0);
	c_clock_mode: cover property (hit && ctrl_q.clock_pulse_select ##[1:200] hit);
	c_pulse_two: cover property (hit && ctrl_q.pulse_width_select ##1 state_q ##[1:20] !state_q);
	c_restart: cover property (restart);

endmodule

// ---- pcom_timer_tb.sv ----
// self-checking bench of the period counter, pin mux and register port
`include "pcom_map.svh"
`define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; $display("unexpected %s exp %h got %h", nm, e, g); end end

module pcom_timer_tb;
	timeunit 1ns;
	timeprecision 1ps;

	// ---------------------------------------------------------------
	// bench signals
	// ---------------------------------------------------------------
	logic        clk = 1'h0;
	logic        nrst = 1'h0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic        wr = 1'h0;
	logic        rd = 1'h0;
	logic [31:0] rdat;
	logic        pin;
	logic        st;
	logic [31:0] u;
	logic [31:0] v;
	logic        pv;
	int          err_count = 0;
	int          samples_checked = 0;
	int          n;
	int          p;

	// cpu clock, 50 MHz
	always #10 clk = ~clk;

	// one tick per cpu clock keeps every count exact
	pcom_timer #(.TICK_DIV(1)) u_dut (.i_core_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wd),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdat), .o_timer_out_pin(pin), .o_timer_state_output(st));

	// register write, one strobe cycle
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'h1;
		@(posedge clk);
		wr <= 1'h0;
	endtask

	// register read, data taken in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'h1;
		@(posedge clk);
		rd <= 1'h0;
		@(negedge clk);
		d = rdat;
	endtask

	// control word from its fields
	function automatic logic [31:0] ctl(input logic ro, iv, gp, wi, rs, al, cp);
		ctl = 32'h0;
		ctl[`PCOM_BIT_ROLE] = ro;
		ctl[`PCOM_BIT_INVERT] = iv;
		ctl[`PCOM_BIT_GPVAL] = gp;
		ctl[`PCOM_BIT_WIDTH] = wi;
		ctl[`PCOM_BIT_RESTART] = rs;
		ctl[`PCOM_BIT_ALLOW] = al;
		ctl[`PCOM_BIT_CLKMODE] = cp;
	endfunction

	// verdict and end of run
	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// cycles until the status output changes, bounded
	task automatic flip(output int c);
		logic s;
		s = st;
		c = 0;
		do
		begin
			@(posedge clk);
			#1;
			c++;
		end
		while (st === s && c < 300);
		if (c >= 300)
		begin
			err_count++;
			complete_run();
		end
	endtask

	// main sequence
	initial
	begin
		void'($urandom(16310));
		repeat (2) @(posedge clk);
		nrst <= 1'h1;
		rreg(`PCOM_OFS_PERIOD, v);
		`CHECK("period", 32'h0, v)
		rreg(`PCOM_OFS_COUNT, v);
		`CHECK("count", 32'h0, v)
		`CHECK("pin", 1'h0, pin)
		wreg(8'h0C, 32'h5A5A_5A5A);
		rreg(8'h0C, v);
		`CHECK("unmapped", 32'h0, v)
		// full width values, corner first then random
		for (int i = 0; i < 4; i++)
		begin
			u = (i == 0) ? 32'hFFFF_FFFF : $urandom;
			wreg(`PCOM_OFS_PERIOD, u);
			wreg(`PCOM_OFS_COUNT, ~u);
			rreg(`PCOM_OFS_PERIOD, v);
			`CHECK("period", u, v)
			rreg(`PCOM_OFS_COUNT, v);
			`CHECK("count", ~u, v)
		end
		// held, then one step per tick
		rreg(`PCOM_OFS_COUNT, u);
		rreg(`PCOM_OFS_COUNT, v);
		`CHECK("held", u, v)
		wreg(`PCOM_OFS_COUNT, 32'h64);
		wreg(`PCOM_OFS_CTRL, ctl(0, 0, 0, 0, 0, 1, 0));
		rreg(`PCOM_OFS_COUNT, u);
		rreg(`PCOM_OFS_COUNT, v);
		`CHECK("step", u + 32'h2, v)
		// restart with and without count allow
		wreg(`PCOM_OFS_CTRL, ctl(0, 0, 0, 0, 1, 1, 0));
		rreg(`PCOM_OFS_COUNT, v);
		`CHECK("restart", 32'h1, v)
		wreg(`PCOM_OFS_CTRL, 32'h0);
		rreg(`PCOM_OFS_COUNT, u);
		wreg(`PCOM_OFS_CTRL, ctl(0, 0, 0, 0, 1, 0, 0));
		rreg(`PCOM_OFS_COUNT, v);
		`CHECK("no restart", u, v)
		rreg(`PCOM_OFS_CTRL, v);
		`CHECK("control", 32'h0, v)
		// clock mode toggles every period plus the zeroing cycle
		p = 32'h3 + $urandom % 32'hA;
		wreg(`PCOM_OFS_PERIOD, 32'(p));
		wreg(`PCOM_OFS_CTRL, ctl(1, 0, 0, 0, 1, 1, 1));
		flip(n);
		flip(n);
		`CHECK("half period", p + 1, n)
		repeat (6)
		begin
			rreg(`PCOM_OFS_COUNT, v);
			`CHECK("in period", 1'h1, v <= 32'(p))
		end
		// every pin role, invert and output value combination
		for (int i = 0; i < 8; i++)
		begin
			wreg(`PCOM_OFS_CTRL, ctl(i[0], i[1], i[2], 0, 0, 1, 1));
			repeat (2) @(posedge clk);
			#1;
			pv = st;
			repeat (12)
			begin
				@(posedge clk);
				#1;
				`CHECK("pin", i[0] ? pv ^ i[1] : i[2], pin)
				pv = st;
			end
		end
		// pulse mode, both widths
		for (int w = 0; w < 2; w++)
		begin
			wreg(`PCOM_OFS_CTRL, ctl(1, 0, 0, w[0], 0, 1, 0));
			flip(n);
			flip(n);
			if (st !== 1'h1)
				flip(n);
			flip(n);
			`CHECK("pulse width", w + 1, n)
		end
		complete_run();
	end
endmodule
